// [hw/prog_access_defs.vh]
`ifndef PROG_ACCESS_DEFS_VH
`define PROG_ACCESS_DEFS_VH

// Program space and vectors
`define PC_W 15
`define PROG_AW 11
`define PROG_WORD_W 14
`define RESET_VEC 15'h0000
`define INT_VEC 15'h0004
`define PC_ONE 15'h0001

// Return stack geometry
`define STK_DEPTH 16
`define STK_PTR_W 5
`define STK_FULL 5'h10
`define STK_EMPTY 5'h00

// Pointer space decode
`define PTR_W 16
`define PTR_PROG_BIT 15
`define LIN_TAG 3'h1
`define BANKED_TAG 4'h0
`define LIN_BANK_SIZE 13'h0050
`define LIN_GPR_BASE 7'h20
`define DMEM_AW 12
`define NVM_AW 8

// Register index map on the software port
`define REG_AW 4
`define REG_PTR0_LO 4'h0
`define REG_PTR0_HI 4'h1
`define REG_PTR1_LO 4'h2
`define REG_PTR1_HI 4'h3
`define REG_PWR_STAT 4'h4
`define REG_CTRL 4'h5
`define REG_IRQ_STAT 4'h6
`define REG_IRQ_MASK 4'h7
`define REG_PC_LO 4'h8
`define REG_PC_HI 4'h9
`define REG_STK_DEPTH 4'hA

// Field positions
`define PWR_UNF_BIT 0
`define PWR_OVF_BIT 1
`define CTRL_STKRST_BIT 0
`define EV_OVF 0
`define EV_UNF 1
`define EV_PWRITE 2
`define EV_W 3

// Prefetch sequencer states
`define ST_IDLE 1'b0
`define ST_PFETCH 1'b1

`endif

// [hw/prog_access.v]
// The implementer's own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "prog_access_defs.vh"

// How it works
// [R1] Sixteen-entry 15-bit return stack, separate storage
// [R2] Full push/empty pop set status flags
// [R3] Enabled stack error causes soft reset
// [R4] Interrupt entry saves, return restores shadows
// [R5] Two 16-bit pointers from byte halves
// [R6] Pointers reach RAM, program and nonvolatile
// [R7] Program-memory indirect read adds one cycle
// [R8] Linear pointer window spans banked GPR
// [R9] Flow commands from the 49-instruction set
// [R10] 15-bit program counter, 32K word space
// [R11] Addresses above implemented memory wrap
// [R12] Reset fetches 0000h, interrupt vectors 0004h
// [R13] 2048-word program memory, last 07FFh
// [R14] Pointer high bit 7 selects program memory
// [R15] Program read returns low eight bits
// [R16] Indirect writes never alter program memory
// [R17] 12-bit data address: bank plus offset
// [R18] Stack flags survive soft reset until cleared
module prog_access (
  input wire sys_clk_i,
  input wire reset_n_i,
  // Software register port
  input wire [3:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output wire [7:0] reg_rdata_o,
  output wire irq_o,
  // Flow commands from the decoder
  input wire pc_advance_i,
  input wire jump_i,
  input wire call_i,
  input wire return_i,
  input wire irq_accept_i,
  input wire irq_return_i,
  input wire [14:0] jump_target_i,
  // Context to shadow
  input wire [7:0] work_reg_i,
  input wire [7:0] status_i,
  input wire [4:0] bank_sel_i,
  input wire [6:0] program_counter_latch_high_i,
  output wire [7:0] shadow_work_o,
  output wire [7:0] shadow_status_o,
  output wire [4:0] shadow_bank_o,
  output wire [6:0] shadow_pclatch_o,
  output wire ctx_restore_o,
  // Indirect data port requests
  input wire ind_read_i,
  input wire ind_write_i,
  input wire ind_sel_i,
  input wire ind_postinc_i,
  output wire stall_o,
  output wire [7:0] ind_rdata_o,
  output wire ind_valid_o,
  // Data memory and nonvolatile memory
  output wire [11:0] dmem_addr_o,
  output wire dmem_rd_o,
  output wire dmem_wr_o,
  output wire [7:0] nvm_addr_o,
  output wire nvm_rd_o,
  output wire nvm_wr_o,
  // Program flash
  output wire [10:0] flash_addr_o,
  input wire [13:0] flash_data_i,
  output wire [14:0] pc_o,
  output wire soft_reset_o
);

  reg [14:0] pc_r;
  reg [14:0] pc_nxt;
  reg [14:0] stack_mem [0:15];
  reg [4:0] sp_r;
  reg [4:0] sp_nxt;
  reg push;
  reg pop;
  reg [14:0] push_val;
  reg ovf_evt;
  reg unf_evt;
  reg stack_overflow_flag_r;
  reg stack_underflow_flag_r;
  reg stkrst_en_r;
  reg soft_rst_r;
  reg [15:0] ptr0_r;
  reg [15:0] ptr1_r;
  reg [15:0] sh_ptr0_r;
  reg [15:0] sh_ptr1_r;
  reg [7:0] sh_work_r;
  reg [7:0] sh_status_r;
  reg [4:0] sh_bank_r;
  reg [6:0] sh_pclatch_r;
  reg ctx_restore_r;
  reg [2:0] irq_stat_r;
  reg [2:0] irq_mask_r;
  reg [7:0] rdata_r;
  reg [7:0] rdata_nxt;
  reg state_r;
  reg [10:0] flash_addr_r;
  reg [7:0] ind_rdata_r;
  reg ind_valid_r;
  reg [11:0] dmem_addr_r;
  reg dmem_rd_r;
  reg dmem_wr_r;
  reg [7:0] nvm_addr_r;
  reg nvm_rd_r;
  reg nvm_wr_r;
  reg pwrite_evt;

  wire idle = (state_r == `ST_IDLE);
  wire [14:0] stack_top = stack_mem[sp_r[3:0] - 4'h1];
  wire stk_full = (sp_r == `STK_FULL);
  wire stk_empty = (sp_r == `STK_EMPTY);

  // Selected pointer and its target class
  wire [15:0] sel_ptr = ind_sel_i ? ptr1_r : ptr0_r;
  wire is_prog = sel_ptr[`PTR_PROG_BIT]; // [R14]
  wire is_lin = ~is_prog & (sel_ptr[15:13] == `LIN_TAG);
  wire is_bank = sel_ptr[15:12] == `BANKED_TAG;
  wire is_nvm = ~is_prog & ~is_lin & ~is_bank; // [R6]

  // Linear window: each bank lends its 80 GPR bytes in turn
  wire [12:0] lin_q = sel_ptr[12:0] / `LIN_BANK_SIZE; // [R8]
  wire [12:0] lin_r = sel_ptr[12:0] % `LIN_BANK_SIZE;
  wire [6:0] lin_off = `LIN_GPR_BASE + lin_r[6:0];
  // Upper five bits pick the bank, lower seven the location
  wire [11:0] lin_addr = {lin_q[4:0], lin_off}; // [R17]
  wire [11:0] bank_addr = sel_ptr[11:0];

  wire cmd_ok = idle & ~soft_rst_r;
  wire evt_ovf_set = ovf_evt;
  wire evt_unf_set = unf_evt;

  // Flow command decode; one command per cycle, highest listed first
  always @* begin
    pc_nxt = pc_r;
    push = 1'b0;
    pop = 1'b0;
    push_val = pc_r;
    if (soft_rst_r) begin
      pc_nxt = `RESET_VEC; // [R12]
    end else if (cmd_ok) begin // [R9]
      if (irq_accept_i) begin
        push = 1'b1;
        push_val = pc_r;
        pc_nxt = `INT_VEC; // [R12]
      end else if (irq_return_i | return_i) begin
        pop = 1'b1;
        pc_nxt = stk_empty ? `RESET_VEC : stack_top;
      end else if (call_i) begin
        push = 1'b1;
        push_val = pc_r + `PC_ONE;
        pc_nxt = jump_target_i;
      end else if (jump_i) begin
        pc_nxt = jump_target_i;
      end else if (pc_advance_i) begin
        pc_nxt = pc_r + `PC_ONE; // [R10]
      end
    end
  end

  // Stack depth and error detection
  always @* begin
    sp_nxt = sp_r;
    ovf_evt = 1'b0;
    unf_evt = 1'b0;
    if (soft_rst_r) begin
      sp_nxt = `STK_EMPTY;
    end else if (push) begin
      if (stk_full) begin
        ovf_evt = 1'b1; // [R2]
      end else begin
        sp_nxt = sp_r + 5'h01;
      end
    end else if (pop) begin
      if (stk_empty) begin
        unf_evt = 1'b1; // [R2]
      end else begin
        sp_nxt = sp_r - 5'h01;
      end
    end
  end

  // Program counter, stack pointer and soft reset
  always @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      pc_r <= `RESET_VEC; // [R12]
      sp_r <= `STK_EMPTY;
      soft_rst_r <= 1'b0;
    end else begin
      pc_r <= pc_nxt;
      sp_r <= sp_nxt;
      // Only the core state restarts; flags stay for diagnosis
      soft_rst_r <= (ovf_evt | unf_evt) & stkrst_en_r; // [R3]
    end
  end

  // Stack array holds no reset; a full stack refuses the write
  always @(posedge sys_clk_i) begin
    if (push && !stk_full) begin
      stack_mem[sp_r[3:0]] <= push_val; // [R1]
    end
  end

  // Shadow capture on entry, restore pulse on return
  always @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      sh_work_r <= 8'h00;
      sh_status_r <= 8'h00;
      sh_bank_r <= 5'h00;
      sh_pclatch_r <= 7'h00;
      sh_ptr0_r <= 16'h0000;
      sh_ptr1_r <= 16'h0000;
      ctx_restore_r <= 1'b0;
    end else begin
      ctx_restore_r <= cmd_ok & ~irq_accept_i & irq_return_i; // [R4]
      if (cmd_ok && irq_accept_i) begin
        sh_work_r <= work_reg_i; // [R4]
        sh_status_r <= status_i;
        sh_bank_r <= bank_sel_i;
        sh_pclatch_r <= program_counter_latch_high_i;
        sh_ptr0_r <= ptr0_r;
        sh_ptr1_r <= ptr1_r;
      end
    end
  end

  // Pointers: bus write beats restore, restore beats post-increment
  always @(posedge sys_clk_i) begin
    if (!reset_n_i || soft_rst_r) begin
      ptr0_r <= 16'h0000;
      ptr1_r <= 16'h0000;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `REG_PTR0_LO: ptr0_r[7:0] <= reg_wdata_i; // [R5]
        `REG_PTR0_HI: ptr0_r[15:8] <= reg_wdata_i;
        `REG_PTR1_LO: ptr1_r[7:0] <= reg_wdata_i;
        `REG_PTR1_HI: ptr1_r[15:8] <= reg_wdata_i;
        default: ptr0_r <= ptr0_r;
      endcase
    end else if (cmd_ok && !irq_accept_i && irq_return_i) begin
      ptr0_r <= sh_ptr0_r; // [R4]
      ptr1_r <= sh_ptr1_r;
    end else if (cmd_ok && ind_postinc_i && (ind_read_i || ind_write_i)) begin
      if (ind_sel_i) begin
        ptr1_r <= ptr1_r + 16'h0001;
      end else begin
        ptr0_r <= ptr0_r + 16'h0001;
      end
    end
  end

  // Indirect access steering and program-memory prefetch
  always @(posedge sys_clk_i) begin
    if (!reset_n_i || soft_rst_r) begin
      state_r <= `ST_IDLE;
      flash_addr_r <= 11'h000;
      ind_rdata_r <= 8'h00;
      ind_valid_r <= 1'b0;
      dmem_addr_r <= 12'h000;
      dmem_rd_r <= 1'b0;
      dmem_wr_r <= 1'b0;
      nvm_addr_r <= 8'h00;
      nvm_rd_r <= 1'b0;
      nvm_wr_r <= 1'b0;
      pwrite_evt <= 1'b0;
    end else begin
      ind_valid_r <= 1'b0;
      dmem_rd_r <= 1'b0;
      dmem_wr_r <= 1'b0;
      nvm_rd_r <= 1'b0;
      nvm_wr_r <= 1'b0;
      pwrite_evt <= 1'b0;
      // Fetch address keeps only the implemented bits
      flash_addr_r <= pc_nxt[10:0]; // [R11] [R13]
      case (state_r)
        `ST_IDLE: begin
          if (cmd_ok && ind_read_i && is_prog) begin
            flash_addr_r <= sel_ptr[10:0]; // [R11]
            state_r <= `ST_PFETCH; // [R7]
          end else if (cmd_ok && ind_write_i && is_prog) begin
            pwrite_evt <= 1'b1; // [R16]
          end else if (cmd_ok && (ind_read_i || ind_write_i)) begin
            if (is_nvm) begin
              nvm_addr_r <= sel_ptr[7:0]; // [R6]
              nvm_rd_r <= ind_read_i;
              nvm_wr_r <= ind_write_i;
            end else begin
              dmem_addr_r <= is_lin ? lin_addr : bank_addr; // [R8]
              dmem_rd_r <= ind_read_i;
              dmem_wr_r <= ind_write_i;
            end
          end
        end
        `ST_PFETCH: begin
          // Extra cycle lets the array answer the data address
          ind_rdata_r <= flash_data_i[7:0]; // [R15]
          ind_valid_r <= 1'b1;
          state_r <= `ST_IDLE;
        end
        default: state_r <= `ST_IDLE;
      endcase
    end
  end

  // Control, stack flags and interrupt registers; set beats clear
  always @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      stack_overflow_flag_r <= 1'b0;
      stack_underflow_flag_r <= 1'b0;
      stkrst_en_r <= 1'b0;
      irq_stat_r <= 3'h0;
      irq_mask_r <= 3'h0;
    end else begin
      // Soft reset does not touch these, so the cause stays visible
      if (evt_ovf_set) begin
        stack_overflow_flag_r <= 1'b1; // [R2] [R18]
      end else if (reg_wr_i && reg_addr_i == `REG_PWR_STAT && reg_wdata_i[`PWR_OVF_BIT]) begin
        stack_overflow_flag_r <= 1'b0;
      end
      if (evt_unf_set) begin
        stack_underflow_flag_r <= 1'b1; // [R2] [R18]
      end else if (reg_wr_i && reg_addr_i == `REG_PWR_STAT && reg_wdata_i[`PWR_UNF_BIT]) begin
        stack_underflow_flag_r <= 1'b0;
      end
      if (reg_wr_i && reg_addr_i == `REG_CTRL) begin
        stkrst_en_r <= reg_wdata_i[`CTRL_STKRST_BIT];
      end
      if (reg_wr_i && reg_addr_i == `REG_IRQ_MASK) begin
        irq_mask_r <= reg_wdata_i[2:0];
      end
      if (reg_wr_i && reg_addr_i == `REG_IRQ_STAT) begin
        irq_stat_r <= (irq_stat_r & ~reg_wdata_i[2:0]) | {pwrite_evt, unf_evt, ovf_evt};
      end else begin
        irq_stat_r <= irq_stat_r | {pwrite_evt, unf_evt, ovf_evt};
      end
    end
  end

  // Read mux; unmapped indices read zero
  always @* begin
    rdata_nxt = 8'h00;
    case (reg_addr_i)
      `REG_PTR0_LO: rdata_nxt = ptr0_r[7:0];
      `REG_PTR0_HI: rdata_nxt = ptr0_r[15:8];
      `REG_PTR1_LO: rdata_nxt = ptr1_r[7:0];
      `REG_PTR1_HI: rdata_nxt = ptr1_r[15:8];
      `REG_PWR_STAT: rdata_nxt = {6'h00, stack_overflow_flag_r, stack_underflow_flag_r};
      `REG_CTRL: rdata_nxt = {7'h00, stkrst_en_r};
      `REG_IRQ_STAT: rdata_nxt = {5'h00, irq_stat_r};
      `REG_IRQ_MASK: rdata_nxt = {5'h00, irq_mask_r};
      `REG_PC_LO: rdata_nxt = pc_r[7:0];
      `REG_PC_HI: rdata_nxt = {1'b0, pc_r[14:8]};
      `REG_STK_DEPTH: rdata_nxt = {3'h0, sp_r};
      default: rdata_nxt = 8'h00;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= reg_rd_i ? rdata_nxt : 8'h00;
    end
  end

  assign reg_rdata_o = rdata_r;
  assign irq_o = |(irq_stat_r & irq_mask_r);
  assign shadow_work_o = sh_work_r;
  assign shadow_status_o = sh_status_r;
  assign shadow_bank_o = sh_bank_r;
  assign shadow_pclatch_o = sh_pclatch_r;
  assign ctx_restore_o = ctx_restore_r;
  assign stall_o = ~idle; // [R7]
  assign ind_rdata_o = ind_rdata_r;
  assign ind_valid_o = ind_valid_r;
  assign dmem_addr_o = dmem_addr_r;
  assign dmem_rd_o = dmem_rd_r;
  assign dmem_wr_o = dmem_wr_r;
  assign nvm_addr_o = nvm_addr_r;
  assign nvm_rd_o = nvm_rd_r;
  assign nvm_wr_o = nvm_wr_r;
  assign flash_addr_o = flash_addr_r;
  assign pc_o = pc_r;
  assign soft_reset_o = soft_rst_r;

endmodule

// [tb/prog_access_properties.sv]
`timescale 1ns/1ps
module prog_access_properties (
  input wire sys_clk_i,
  input wire reset_n_i,
  input wire pc_advance_i,
  input wire jump_i,
  input wire call_i,
  input wire return_i,
  input wire irq_accept_i,
  input wire irq_return_i,
  input wire [7:0] work_reg_i,
  input wire [4:0] bank_sel_i,
  input wire stall_o,
  input wire soft_reset_o,
  input wire [14:0] pc_o,
  input wire [10:0] flash_addr_o,
  input wire [13:0] flash_data_i,
  input wire [7:0] ind_rdata_o,
  input wire ind_valid_o,
  input wire ctx_restore_o,
  input wire [7:0] shadow_work_o,
  input wire [4:0] shadow_bank_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  // Commands are ignored while stalled or restarting
  wire ok = !stall_o && !soft_reset_o;
  wire others = jump_i | call_i | return_i | irq_accept_i | irq_return_i;
  wire adv = pc_advance_i & !others;
  reg [7:0] fd_r;
  // Array byte seen in the prefetch cycle
  always @(posedge sys_clk_i) fd_r <= flash_data_i[7:0];
  sequence s_fetch;
    stall_o ##1 (!stall_o && ind_valid_o);
  endsequence
  sequence s_vec;
    pc_o == 15'h0004 && flash_addr_o == 11'h004;
  endsequence
  pc_step_a: assert property (adv && ok |=> pc_o == $past(pc_o) + 15'h0001)
    else $error("pc did not step");
  fetch_track_a: assert property ((pc_advance_i | others) && ok |=> flash_addr_o == pc_o[10:0])
    else $error("fetch address off pc");
  irq_vector_a: assert property (irq_accept_i && ok |=> s_vec)
    else $error("bad interrupt vector");
  soft_restart_a: assert property (soft_reset_o |=> pc_o == 15'h0000 && !soft_reset_o)
    else $error("no restart at zero");
  extra_cycle_a: assert property ($rose(stall_o) |-> s_fetch)
    else $error("prefetch not one cycle");
  low_byte_a: assert property (stall_o |=> ind_rdata_o == fd_r)
    else $error("wrong program byte");
  ctx_restore_a: assert property (irq_return_i && !irq_accept_i && ok |=> ctx_restore_o)
    else $error("no context restore");
  shadow_save_a: assert property (irq_accept_i && ok |=>
    shadow_work_o == $past(work_reg_i) && shadow_bank_o == $past(bank_sel_i))
    else $error("shadow not captured");
endmodule

// [tb/flash_array_model.sv]
`timescale 1ns/1ps
// Asynchronous array; neighbouring words always differ
module flash_array_model (
  input wire [10:0] addr_i,
  output wire [13:0] data_o
);
  // Upper bits scrambled so a wrong slice shows
  assign data_o = {addr_i[2:0], addr_i} ^ 14'h2A5B;
endmodule

// [tb/testbench.sv]
`timescale 1ns/1ps
module testbench;
  reg sys_clk_i, reset_n_i, reg_wr_i, reg_rd_i, ind_read_i, ind_write_i, ind_sel_i, ind_postinc_i;
  reg pc_advance_i, jump_i, call_i, return_i, irq_accept_i, irq_return_i;
  reg [3:0] reg_addr_i;
  reg [7:0] reg_wdata_i, work_reg_i, status_i;
  reg [14:0] jump_target_i, pc, stk [0:15];
  reg [4:0] bank_sel_i;
  reg [6:0] program_counter_latch_high_i;
  wire [7:0] reg_rdata_o, shadow_work_o, shadow_status_o, ind_rdata_o, nvm_addr_o;
  wire [4:0] shadow_bank_o;
  wire [6:0] shadow_pclatch_o;
  wire [11:0] dmem_addr_o;
  wire [10:0] flash_addr_o;
  wire [13:0] flash_data_i;
  wire [14:0] pc_o;
  wire irq_o, ctx_restore_o, stall_o, ind_valid_o, dmem_rd_o, dmem_wr_o, nvm_rd_o, nvm_wr_o, soft_reset_o;
  integer n_mismatch = 0, checks_done = 0, i, k;
  reg [31:0] r;
  reg [15:0] p;
  reg [12:0] n;
  localparam ADV = 6'h01, JMP = 6'h02, CALL = 6'h04, RET = 6'h08, ACC = 6'h10, IRET = 6'h20;

  prog_access prog_access_inst (.*);
  flash_array_model flash_array_model_inst (.addr_i(flash_addr_o), .data_o(flash_data_i));

  always #4 sys_clk_i = !sys_clk_i;

  task summarize;
    if (n_mismatch == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input [15:0] got, input [15:0] exp);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Linear window: 80 bytes per bank from offset 20h
  function [11:0] lin(input [12:0] m);
    reg [12:0] b, o;
    b = m / 13'h0050;
    o = m % 13'h0050 + 13'h0020;
    lin = {b[4:0], o[6:0]};
  endfunction
  // Tasks drive after a rising edge and sample at the falling one
  task wr(input [3:0] a, input [7:0] d);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'h1;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'h0;
  endtask
  task rdc(input [3:0] a, input [7:0] e);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'h1;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'h0;
    @(negedge sys_clk_i);
    chk(reg_rdata_o, e);
  endtask
  task go(input [5:0] c, input [14:0] t, input [14:0] e);
    @(posedge sys_clk_i);
    {irq_return_i, irq_accept_i, return_i, call_i, jump_i, pc_advance_i} <= c;
    jump_target_i <= t;
    @(posedge sys_clk_i);
    {irq_return_i, irq_accept_i, return_i, call_i, jump_i, pc_advance_i} <= 6'h00;
    @(negedge sys_clk_i);
    chk(pc_o, e);
    chk(flash_addr_o, e[10:0]);
    pc = e;
  endtask
  task ind(input w, input s, input [15:0] q);
    wr({2'h0, s, 1'h0}, q[7:0]);
    wr({2'h0, s, 1'h1}, q[15:8]);
    @(posedge sys_clk_i);
    ind_sel_i <= s;
    ind_postinc_i <= r[28];
    ind_read_i <= !w;
    ind_write_i <= w;
    @(posedge sys_clk_i);
    ind_read_i <= 1'h0;
    ind_write_i <= 1'h0;
    @(negedge sys_clk_i);
  endtask

  initial begin
    {sys_clk_i, reset_n_i, reg_wr_i, reg_rd_i, ind_read_i, ind_write_i, ind_sel_i, ind_postinc_i} = 8'h00;
    {irq_return_i, irq_accept_i, return_i, call_i, jump_i, pc_advance_i} = 6'h00;
    {reg_addr_i, reg_wdata_i, jump_target_i, work_reg_i, status_i, bank_sel_i, program_counter_latch_high_i} = '0;
    r = $urandom(32'h6C04CDDB);
    repeat (2) @(posedge sys_clk_i);
    reset_n_i <= 1'h1;
    @(negedge sys_clk_i);
    chk(pc_o, 15'h0000);
    r = $urandom;
    wr(4'h2, r[7:0]);
    wr(4'h3, r[15:8]);
    rdc(4'h2, r[7:0]);
    rdc(4'h3, r[15:8]);
    rdc(4'hF, 8'h00);
    // Run across the top of program space
    go(JMP, 15'h7FFE, 15'h7FFE);
    go(ADV, 0, 15'h7FFF);
    go(ADV, 0, 15'h0000);
    go(JMP, 15'h0FFF, 15'h0FFF);
    for (i = 0; i < 8; i++) go(ADV, 0, pc + 15'h1);
    // Fill the stack; same target so a refused push keeps pc
    for (i = 0; i < 16; i++) begin
      r = $urandom;
      stk[i] = pc + 15'h1;
      go(CALL, r[14:0], r[14:0]);
    end
    rdc(4'hA, 8'h10);
    go(CALL, pc, pc);
    rdc(4'h4, 8'h02);
    rdc(4'h6, 8'h01);
    chk(irq_o, 1'h0);
    wr(4'h7, 8'h01);
    @(negedge sys_clk_i);
    chk(irq_o, 1'h1);
    for (i = 15; i >= 0; i--) go(RET, 0, stk[i]);
    go(RET, 0, 15'h0000);
    rdc(4'h4, 8'h03);
    wr(4'h6, 8'h07);
    @(negedge sys_clk_i);
    chk(irq_o, 1'h0);
    wr(4'h4, 8'h03);
    rdc(4'h4, 8'h00);
    // Overflow with the reset option on
    wr(4'h5, 8'h01);
    for (i = 0; i < 16; i++) go(CALL, pc + 15'h1, pc + 15'h1);
    go(CALL, pc, pc);
    for (k = 0; k < 4 && soft_reset_o !== 1'h1; k++) @(negedge sys_clk_i);
    chk(soft_reset_o, 1'h1);
    @(negedge sys_clk_i);
    chk(pc_o, 15'h0000);
    rdc(4'hA, 8'h00);
    rdc(4'h4, 8'h02);
    wr(4'h5, 8'h00);
    // Interrupt with random context
    go(JMP, 15'h0321, 15'h0321);
    r = $urandom;
    @(posedge sys_clk_i);
    {program_counter_latch_high_i, bank_sel_i, status_i, work_reg_i} <= r[27:0];
    go(ACC, 0, 15'h0004);
    chk(shadow_work_o, r[7:0]);
    chk(shadow_status_o, r[15:8]);
    chk(shadow_bank_o, r[20:16]);
    chk(shadow_pclatch_o, r[27:21]);
    go(IRET, 0, 15'h0321);
    chk(ctx_restore_o, 1'h1);
    rdc(4'h8, 8'h21);
    rdc(4'h9, 8'h03);
    // Reads over all four targets, linear corners first
    for (i = 0; i < 24; i++) begin
      r = $urandom;
      n = (i == 0) ? 13'h0000 : (i == 1) ? 13'h004F : (i == 2) ? 13'h0050 : {1'h0, r[11:0]} % 13'h0A00;
      k = (i < 3) ? 1 : r[31:30];
      p = (k == 0) ? {1'h1, r[14:0]} : (k == 1) ? {3'h1, n} : (k == 2) ? {4'h0, r[11:0]} : {4'h4, r[11:0]};
      ind(1'h0, r[29], p);
      if (k == 0) begin
        chk(stall_o, 1'h1);
        chk(flash_addr_o, p[10:0]);
        @(negedge sys_clk_i);
        chk(ind_valid_o, 1'h1);
        chk(ind_rdata_o, p[7:0] ^ 8'h5B);
      end else if (k == 3) begin
        chk({nvm_rd_o, nvm_addr_o}, {1'h1, p[7:0]});
      end else begin
        chk({dmem_rd_o, dmem_addr_o}, {1'h1, (k == 1) ? lin(n) : p[11:0]});
      end
      // Post-increment shows in the low byte of the chosen pointer
      rdc({2'h0, r[29], 1'h0}, p[7:0] + r[28]);
    end
    // Writes aimed at program space are dropped and flagged
    ind(1'h1, 1'h0, 16'h8123);
    chk({dmem_wr_o, nvm_wr_o}, 2'h0);
    // Overflow bit from the soft reset run is still pending
    rdc(4'h6, 8'h05);
    // Writes to RAM and nonvolatile targets do reach their ports
    ind(1'h1, 1'h1, 16'h0055);
    chk({dmem_wr_o, dmem_addr_o}, {1'h1, 12'h055});
    ind(1'h1, 1'h0, 16'h4077);
    chk({nvm_wr_o, nvm_addr_o}, {1'h1, 8'h77});
    summarize;
  end

  // Cut a hung run short
  initial begin
    #100000;
    n_mismatch = n_mismatch + 1;
    summarize;
  end
endmodule

bind prog_access prog_access_properties prog_access_properties_inst (.*);
